// ### bench/mdl_dte_checker.sv
// Purpose: Port assertions for the DTE control-line block
// Assumes: Options stay stable from reset onward
// Notes:   Bound into every mdl_dte_lines instance
`timescale 1ns/100ps
module mdl_dte_checker #(
  parameter int unsigned DTR_FILTER_CYC = 8
) (
  input wire logic       clk_i, nrst_i, req_send_n_pin_i, term_ready_n_pin_i,
  input wire logic       rx_serial_n_pin_o, clear_send_n_pin_o, ring_ind_n_pin_o,
  input wire logic       set_ready_n_pin_o, carrier_det_n_pin_o,
  input wire logic [1:0] clear_send_option_i,
  input wire logic [7:0] ring_count_i,
  input wire logic       set_ready_tracks_connection_i, carrier_forced_on_i,
  input wire logic       async_mode_option_i, half_duplex_i, test_mode_select_i,
  input wire logic       ring_on_i, carrier_i, line_rx_bit_i, resp_active_i, resp_bit_i,
  input wire logic       tx_enable_o, dte_accept_o, off_hook_o,
  input wire logic       handshake_start_o, disconnect_o, auto_answer_en_o
);
  logic [2:0] up_q;
  logic [4:0] off_q;
  logic       strap;
  assign strap = clear_send_option_i == mdl_pkg::CTS_FORCED_ON;
  // Saturating counts: cycles since reset, cycles with terminal-ready off
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_q  <= 3'h0;
      off_q <= 5'h0;
    end else begin
      up_q  <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      off_q <= !term_ready_n_pin_i ? 5'h0 : ((off_q == 5'h1f) ? off_q : off_q + 5'h1);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  rx_source_a: assert property (up_q > 3'h1 |-> rx_serial_n_pin_o ==
    !($past(resp_active_i) ? $past(resp_bit_i) : $past(line_rx_bit_i))) else $error("rx source");
  ring_follow_a: assert property (up_q > 3'h1 |->
    ring_ind_n_pin_o == !$past(ring_on_i)) else $error("ring indicate");
  carrier_det_a: assert property (up_q > 3'h2 |->
    carrier_det_n_pin_o == !($past(carrier_i) || carrier_forced_on_i)) else $error("carrier det");
  rts_quiet_a: assert property ((req_send_n_pin_i && !half_duplex_i && !strap)[*4]
    |-> !tx_enable_o) else $error("transmit without rts");
  cts_needs_rts_a: assert property ((req_send_n_pin_i && !strap)[*6]
    |-> clear_send_n_pin_o) else $error("cts without rts");
  cts_strap_a: assert property (up_q > 3'h4 && strap
    |-> !clear_send_n_pin_o && dte_accept_o) else $error("cts strap");
  dsr_test_a: assert property (
    (set_ready_tracks_connection_i && test_mode_select_i)[*4] |-> set_ready_n_pin_o)
    else $error("dsr in test");
  dsr_always_a: assert property (up_q > 3'h4 && !set_ready_tracks_connection_i &&
    async_mode_option_i |-> !set_ready_n_pin_o) else $error("dsr always on");
  dsr_dtr_off_a: assert property (set_ready_tracks_connection_i &&
    off_q > DTR_FILTER_CYC + 4 |-> set_ready_n_pin_o) else $error("dsr after dtr off");
  answer_gate_a: assert property (auto_answer_en_o |-> ring_count_i != 8'h00)
    else $error("auto answer gate");
  answer_pulse_a: assert property (handshake_start_o |->
    off_hook_o ##1 !handshake_start_o) else $error("answer pulse");
  disc_pulse_a: assert property (disconnect_o |=> !disconnect_o)
    else $error("disc pulse");
  cover property (handshake_start_o);
  cover property (disconnect_o);
  cover property (!ring_ind_n_pin_o);
  cover property (set_ready_tracks_connection_i && !set_ready_n_pin_o);
endmodule // mdl_dte_checker

bind mdl_dte_lines mdl_dte_checker #(.DTR_FILTER_CYC(DTR_FILTER_CYC)) u_chk (.*);

// ### bench/mdl_dte_lines_bench.sv
// Purpose: Self-checking bench for the DTE control-line block
// Assumes: Short terminal-ready filter for quick runs
// Notes:   Four resets, each with its own option set
`timescale 1ns/100ps
module mdl_dte_lines_bench;
  localparam int unsigned FILT = 8;
  localparam logic [7:0]  DATA = 8'ha5;
  logic       clk_i, nrst_i, rts_n, txd_n, dtr_n, rxd_n, cts_n, ri_n, dsr_n, dcd_n;
  logic [1:0] opt_cts, opt_dtr;
  logic [7:0] ring_cnt;
  logic       opt_track, opt_force, opt_async, half_dup, test_mode, ring_on, carrier;
  logic       carr_sent, connected, ans_mode, line_bit, resp_act, resp_bit, ready, send;
  logic       tx_en, tx_bit, accept, off_hook, hs, disc, cmd_mode, auto_en, hs_seen, disc_seen;
  int         n_mismatch, checked, cyc;
  // Row: ring, carrier, resp active, resp bit, line bit | ri_n, dcd_n, rxd_n
  logic [7:0] rows [6] = '{8'h83, 8'h4c, 8'h36, 8'h2f, 8'hc8, 8'h07};

  mdl_dte_lines #(.DTR_FILTER_CYC(FILT)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .req_send_n_pin_i(rts_n), .tx_serial_n_pin_i(txd_n),
    .term_ready_n_pin_i(dtr_n), .rx_serial_n_pin_o(rxd_n), .clear_send_n_pin_o(cts_n),
    .ring_ind_n_pin_o(ri_n), .set_ready_n_pin_o(dsr_n), .carrier_det_n_pin_o(dcd_n),
    .clear_send_option_i(opt_cts), .set_ready_tracks_connection_i(opt_track),
    .carrier_forced_on_i(opt_force), .term_ready_option_i(opt_dtr),
    .async_mode_option_i(opt_async), .half_duplex_i(half_dup), .ring_count_i(ring_cnt),
    .test_mode_select_i(test_mode), .ring_on_i(ring_on), .carrier_i(carrier),
    .carrier_sent_i(carr_sent), .connected_i(connected), .answer_mode_i(ans_mode),
    .line_rx_bit_i(line_bit), .resp_active_i(resp_act), .resp_bit_i(resp_bit),
    .tx_enable_o(tx_en), .tx_line_bit_o(tx_bit), .dte_accept_o(accept), .off_hook_o(off_hook),
    .handshake_start_o(hs), .disconnect_o(disc), .command_mode_o(cmd_mode),
    .auto_answer_en_o(auto_en));
  mdl_dte_model u_dte (
    .clk_i(clk_i), .nrst_i(nrst_i), .ready_i(ready), .send_i(send), .data_i(DATA),
    .clear_send_n_pin_i(cts_n), .set_ready_n_pin_i(dsr_n), .req_send_n_pin_o(rts_n),
    .tx_serial_n_pin_o(txd_n), .term_ready_n_pin_o(dtr_n));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Pulses are one cycle wide, so latch them
  always @(posedge clk_i) begin
    if (hs) hs_seen <= 1'b1;
    if (disc) disc_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic do_reset(input logic [1:0] c, input logic [2:0] o, input logic [7:0] rc);
    nrst_i <= 1'b0;
    opt_cts <= c;
    {opt_track, opt_force, test_mode} <= o;
    ring_cnt <= rc;
    {hs_seen, disc_seen} <= 2'b00;
    tick(8);
    chk("reset pins", 8'h3f, {2'h0, rxd_n, cts_n, ri_n, dsr_n, dcd_n, cmd_mode});
    nrst_i <= 1'b1;
    tick(3);
  endtask

  initial begin
    {nrst_i, ready, send, half_dup, carrier, carr_sent, connected, ans_mode} = 8'h00;
    {ring_on, line_bit, resp_act, resp_bit, opt_force, opt_track, test_mode} = 7'h00;
    {opt_cts, opt_dtr, opt_async, ring_cnt, hs_seen, disc_seen} = {4'h2, 1'b1, 10'h0};
    {n_mismatch, checked, cyc} = '0;
    do_reset(mdl_pkg::CTS_FOLLOW_RTS, 3'h0, 8'h00);
    foreach (rows[i]) begin
      {ring_on, carrier, resp_act, resp_bit, line_bit} <= rows[i][7:3];
      tick(3);
      chk("rows", {5'h0, rows[i][2:0]}, {5'h0, ri_n, dcd_n, rxd_n});
      chk("dsr tx_en", 8'h00, {6'h0, dsr_n, tx_en});
    end
    $display("table done");
    do_reset(mdl_pkg::CTS_FOLLOW_RTS, 3'h0, 8'h02);
    ready <= 1'b1;
    tick(FILT + 6);
    repeat (2) begin
      ring_on <= 1'b1;
      tick(3);
      ring_on <= 1'b0;
      tick(3);
    end
    chk("answer", 8'h03, {6'h0, auto_en, hs_seen & off_hook});
    {connected, carrier, carr_sent, ans_mode} <= 4'hf;
    tick(6);
    chk("no rts", 8'h04, {5'h0, cts_n, tx_en, cmd_mode});
    send <= 1'b1;
    for (int k = 0; k < 40 && tx_bit !== 1'b0; k++) tick(1);
    send <= 1'b0;
    // Start bit on the line with the transmitter enabled
    chk("start", 8'h02, {5'h0, cts_n, tx_en, tx_bit});
    for (int b = 0; b < 8; b++) begin
      tick(1);
      chk("tx bit", {7'h0, DATA[b]}, {7'h0, tx_bit});
    end
    $display("transfer done");
    ready <= 1'b0;
    tick(FILT / 2);
    ready <= 1'b1;
    tick(FILT + 6);
    chk("dtr glitch", 8'h01, {6'h0, disc_seen, off_hook});
    ready <= 1'b0;
    tick(FILT + 8);
    chk("dtr off", 8'h02, {6'h0, disc_seen, off_hook});
    $display("terminal ready done");
    // Carrier dropped, so only the forced option can pull carrier-detect on
    {connected, carrier, carr_sent, ans_mode} <= 4'h0;
    do_reset(mdl_pkg::CTS_FORCED_ON, 3'h7, 8'h00);
    ready <= 1'b1;
    tick(FILT + 6);
    chk("strap cts", 8'h01, {6'h0, cts_n, accept});
    chk("strap dsr", 8'h02, {5'h0, dcd_n, dsr_n, auto_en});
    {test_mode, ready} <= 2'b00;
    tick(FILT + 10);
    chk("dsr dtr off", 8'h01, {7'h0, dsr_n});
    $display("options done");
    // Call held through terminal-ready loss, so only tracking turns set-ready off
    opt_dtr <= mdl_pkg::DTR_IGNORE;
    do_reset(mdl_pkg::CTS_FOLLOW_CARR, 3'h4, 8'h01);
    ready <= 1'b1;
    tick(FILT + 6);
    ring_on <= 1'b1;
    tick(3);
    ring_on <= 1'b0;
    tick(3);
    chk("dsr wait", 8'h03, {6'h0, hs_seen, dsr_n});
    carrier <= 1'b1;
    tick(3);
    chk("dsr on", 8'h01, {5'h0, dsr_n, dcd_n, cts_n});
    ready <= 1'b0;
    tick(FILT + 8);
    chk("dtr ignored", 8'h05, {5'h0, dsr_n, disc_seen, off_hook});
    $display("tracking done");
    give_verdict();
  end
endmodule // mdl_dte_lines_bench

// ### bench/mdl_dte_model.sv
// Purpose: Terminal-side model driving handshake and serial data
// Assumes: One bit per clock, 8 data bits, one stop bit
// Notes:   Idle line is mark, which is a low pin
`timescale 1ns/100ps
module mdl_dte_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       ready_i,
  input  wire logic       send_i,
  input  wire logic [7:0] data_i,
  input  wire logic       clear_send_n_pin_i,
  input  wire logic       set_ready_n_pin_i,
  output logic            req_send_n_pin_o,
  output logic            tx_serial_n_pin_o,
  output logic            term_ready_n_pin_o
);
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_q              <= 4'h0;
      sh_q               <= 9'h1ff;
      req_send_n_pin_o   <= 1'b1;
      tx_serial_n_pin_o  <= 1'b0;
      term_ready_n_pin_o <= 1'b1;
    end else begin
      term_ready_n_pin_o <= !ready_i;
      req_send_n_pin_o   <= !(send_i || bit_q != 4'h0);
      if (bit_q != 4'h0) begin
        bit_q             <= (bit_q == 4'h9) ? 4'h0 : bit_q + 4'h1;
        tx_serial_n_pin_o <= !sh_q[0];
        sh_q              <= {1'b1, sh_q[8:1]};
      end else if (send_i && !clear_send_n_pin_i && !set_ready_n_pin_i) begin
        bit_q             <= 4'h1;
        tx_serial_n_pin_o <= 1'b1;
        sh_q              <= {1'b1, data_i};
      end else begin
        tx_serial_n_pin_o <= 1'b0;
      end
    end
  end
endmodule // mdl_dte_model

// ### logic/mdl_dte_lines.sv
// Purpose: Modem-side DTE serial data and handshake line control
// Assumes: One 40 MHz clock; option bits come from the command layer
// Notes:   All pin signals are active low; ON is a low level
`timescale 1ns/100ps
module mdl_dte_lines #(
  parameter int unsigned DTR_FILTER_CYC = mdl_pkg::DTR_FILTER_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // DTE pins, active low
  input  wire logic       req_send_n_pin_i,
  input  wire logic       tx_serial_n_pin_i,
  input  wire logic       term_ready_n_pin_i,
  output logic            rx_serial_n_pin_o,
  output logic            clear_send_n_pin_o,
  output logic            ring_ind_n_pin_o,
  output logic            set_ready_n_pin_o,
  output logic            carrier_det_n_pin_o,
  // Options; all but half duplex and test mode select are stored at reset
  input  wire logic [1:0] clear_send_option_i,
  input  wire logic       set_ready_tracks_connection_i,
  input  wire logic       carrier_forced_on_i,
  input  wire logic [1:0] term_ready_option_i,
  input  wire logic       async_mode_option_i,
  input  wire logic       half_duplex_i,
  input  wire logic [7:0] ring_count_i,
  input  wire logic       test_mode_select_i,
  // Line side status
  input  wire logic       ring_on_i,
  input  wire logic       carrier_i,
  input  wire logic       carrier_sent_i,
  input  wire logic       connected_i,
  input  wire logic       answer_mode_i,
  input  wire logic       line_rx_bit_i,
  input  wire logic       resp_active_i,
  input  wire logic       resp_bit_i,
  // Line side control
  output logic            tx_enable_o,
  output logic            tx_line_bit_o,
  output logic            dte_accept_o,
  output logic            off_hook_o,
  output logic            handshake_start_o,
  output logic            disconnect_o,
  output logic            command_mode_o,
  output logic            auto_answer_en_o
);
  typedef enum {ST_IDLE, ST_HANDSHAKE, ST_DATA, ST_DISC} mdl_state_t;

  mdl_state_t state_q, state_d;
  logic [1:0] cts_opt_q, cts_opt_d, dtr_opt_q, dtr_opt_d;
  logic       dsr_trk_q, dsr_trk_d, dcd_frc_q, dcd_frc_d, async_q, async_d;
  logic [7:0] rcnt_q, rcnt_d, rings_q, rings_d;
  logic       opt_load_q, opt_load_d;
  logic       rts_m_q, rts_s_q, txd_m_q, txd_s_q;
  logic       dtr_on, dtr_prev_q, dtr_fall, ring_prev_q, ring_rise;
  logic       dsr_on, cts_on, dsr_d, dsr_q, cts_q, dcd_q, ri_q, rxd_q, txb_q;
  logic       txen_d, txen_q, acc_d, acc_q, hook_d, hook_q;
  logic       hs_d, hs_q, disc_d, disc_q, cmd_d, cmd_q;
  logic       term_ready_n_f, in_call;

  // Ten-millisecond debounce also synchronises the pin
  mdl_filter #(
    .STABLE_CYC (DTR_FILTER_CYC),
    .RST_VAL    (1'b1)
  ) u_dtr_filter (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .raw_i   (term_ready_n_pin_i),
    .level_o (term_ready_n_f)
  );

  assign dtr_on    = !term_ready_n_f;
  assign dtr_fall  = dtr_prev_q && !dtr_on;
  assign ring_rise = ring_on_i && !ring_prev_q;
  // A late terminal-ready edge must not stretch the disconnect pulse
  assign in_call   = state_q == ST_HANDSHAKE || state_q == ST_DATA;

  // Options captured once after reset release, then held
  always_comb begin
    opt_load_d = 1'b0;
    cts_opt_d  = cts_opt_q;
    dtr_opt_d  = dtr_opt_q;
    dsr_trk_d  = dsr_trk_q;
    dcd_frc_d  = dcd_frc_q;
    async_d    = async_q;
    rcnt_d     = rcnt_q;
    if (opt_load_q) begin
      cts_opt_d = clear_send_option_i;
      dtr_opt_d = term_ready_option_i;
      dsr_trk_d = set_ready_tracks_connection_i;
      dcd_frc_d = carrier_forced_on_i;
      async_d   = async_mode_option_i;
      rcnt_d    = ring_count_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opt_load_q <= 1'b1;
      cts_opt_q  <= mdl_pkg::CTS_OPT_RST;
      dtr_opt_q  <= mdl_pkg::DTR_OPT_RST;
      dsr_trk_q  <= mdl_pkg::DSR_TRACK_RST;
      dcd_frc_q  <= mdl_pkg::DCD_FORCE_RST;
      async_q    <= mdl_pkg::ASYNC_RST;
      rcnt_q     <= mdl_pkg::RING_COUNT_RST;
    end else begin
      opt_load_q <= opt_load_d;
      cts_opt_q  <= cts_opt_d;
      dtr_opt_q  <= dtr_opt_d;
      dsr_trk_q  <= dsr_trk_d;
      dcd_frc_q  <= dcd_frc_d;
      async_q    <= async_d;
      rcnt_q     <= rcnt_d;
    end
  end

  // Connection state machine
  always_comb begin
    state_d = state_q;
    rings_d = rings_q;
    hook_d  = hook_q;
    hs_d    = 1'b0;
    disc_d  = 1'b0;
    cmd_d   = cmd_q;
    case (state_q)
      ST_IDLE: begin
        hook_d = 1'b0;
        if (!ring_on_i && !dtr_on) begin
          rings_d = 8'h00;
        end
        if (ring_rise && dtr_on && rcnt_q != 8'h00) begin
          rings_d = rings_q + 8'h01;
          if (rings_q + 8'h01 >= rcnt_q) begin
            state_d = ST_HANDSHAKE;
            hook_d  = 1'b1;
            hs_d    = 1'b1;
          end
        end
      end
      ST_HANDSHAKE: begin
        if (connected_i) begin
          state_d = ST_DATA;
          cmd_d   = 1'b0;
        end
      end
      ST_DATA: begin
        if (!connected_i) begin
          state_d = ST_DISC;
        end
      end
      ST_DISC: begin
        hook_d  = 1'b0;
        disc_d  = 1'b1;
        rings_d = 8'h00;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Terminal-ready on keeps the call; off acts per option in async mode, always hangs up otherwise
    if (dtr_fall && async_q && in_call) begin
      case (dtr_opt_q)
        mdl_pkg::DTR_IGNORE:     cmd_d = cmd_q;
        mdl_pkg::DTR_TO_COMMAND: cmd_d = 1'b1;
        mdl_pkg::DTR_HANGUP:     state_d = ST_DISC;
        mdl_pkg::DTR_RESET:      state_d = ST_DISC;
        default:                 state_d = ST_DISC;
      endcase
    end
    if (dtr_fall && !async_q && in_call) begin
      state_d = ST_DISC;
    end
  end

  // Handshake outputs
  always_comb begin
    // Tracking mode: on once carrier (sent, when answering) is up in a call, off in test, idle, disconnect or without terminal-ready
    if (async_q && !dsr_trk_q) begin
      dsr_d = 1'b1;
    end else if (dsr_trk_q) begin
      if (test_mode_select_i || !dtr_on) begin
        dsr_d = 1'b0;
      end else if (state_q == ST_IDLE || state_q == ST_DISC) begin
        dsr_d = 1'b0;
      end else if (dsr_q) begin
        dsr_d = 1'b1;
      end else begin
        dsr_d = answer_mode_i ? carrier_sent_i : carrier_i;
      end
    end else begin
      dsr_d = 1'b1;
    end
  end

  assign dsr_on = dsr_q;

  always_comb begin
    case (cts_opt_q)
      mdl_pkg::CTS_FORCED_ON:   cts_on = 1'b1;
      mdl_pkg::CTS_FOLLOW_CARR: cts_on = dtr_on && rts_s_q && carrier_i && connected_i;
      default:                  cts_on = dtr_on && rts_s_q && connected_i;
    endcase
  end

  always_comb begin
    // Forced strap accepts data even with request-to-send off
    acc_d  = cts_q && (rts_s_q || cts_opt_q == mdl_pkg::CTS_FORCED_ON);
    // Transmit needs every handshake on; half duplex direction from RTS
    txen_d = acc_d && rts_s_q && dsr_on && dtr_on && state_q == ST_DATA;
    if (half_duplex_i && !rts_s_q) begin
      txen_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q     <= ST_IDLE;
      rings_q     <= 8'h00;
      hook_q      <= 1'b0;
      hs_q        <= 1'b0;
      disc_q      <= 1'b0;
      cmd_q       <= 1'b1;
      rts_m_q     <= 1'b0;
      rts_s_q     <= 1'b0;
      txd_m_q     <= 1'b0;
      txd_s_q     <= 1'b0;
      dtr_prev_q  <= 1'b0;
      ring_prev_q <= 1'b0;
      dsr_q       <= 1'b0;
      cts_q       <= 1'b0;
      dcd_q       <= 1'b0;
      ri_q        <= 1'b0;
      rxd_q       <= 1'b0;
      txb_q       <= 1'b0;
      txen_q      <= 1'b0;
      acc_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      rings_q     <= rings_d;
      hook_q      <= hook_d;
      hs_q        <= hs_d;
      disc_q      <= disc_d;
      cmd_q       <= cmd_d;
      // Pins inverted to ON-high internally, then two-stage synchronised
      rts_m_q     <= !req_send_n_pin_i;
      rts_s_q     <= rts_m_q;
      txd_m_q     <= !tx_serial_n_pin_i;
      txd_s_q     <= txd_m_q;
      dtr_prev_q  <= dtr_on;
      ring_prev_q <= ring_on_i;
      dsr_q       <= dsr_d;
      cts_q       <= cts_on;
      dcd_q       <= dcd_frc_q || carrier_i;
      ri_q        <= ring_on_i;
      // Responses win the receive line over line data
      rxd_q       <= resp_active_i ? resp_bit_i : line_rx_bit_i;
      txb_q       <= txd_s_q;
      txen_q      <= txen_d;
      acc_q       <= acc_d;
    end
  end

  // Pins driven low for ON
  assign rx_serial_n_pin_o   = !rxd_q;
  assign clear_send_n_pin_o  = !cts_q;
  assign ring_ind_n_pin_o    = !ri_q;
  assign set_ready_n_pin_o   = !dsr_q;
  assign carrier_det_n_pin_o = !dcd_q;
  assign tx_enable_o         = txen_q;
  // Idle mark when not enabled
  assign tx_line_bit_o       = txen_q ? txb_q : 1'b1;
  assign dte_accept_o        = acc_q;
  assign off_hook_o          = hook_q;
  assign handshake_start_o   = hs_q;
  assign disconnect_o        = disc_q;
  assign command_mode_o      = cmd_q;
  assign auto_answer_en_o    = dtr_on && rcnt_q != 8'h00;
endmodule // mdl_dte_lines

// ### logic/mdl_filter.sv
// Purpose: Synchronise and debounce one active-low level input
// Assumes: Input may be asynchronous to clk_i
// Notes:   Output changes only after the level has held for STABLE_CYC cycles
`timescale 1ns/100ps
module mdl_filter #(
  parameter int unsigned STABLE_CYC = 400_000,
  parameter logic        RST_VAL    = 1'b1
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Level
  input  wire logic raw_i,
  output logic      level_o
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  logic          meta_q, sync_q, level_q;
  logic          meta_d, sync_d, level_d;
  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    meta_d  = raw_i;
    sync_d  = meta_q;
    level_d = level_q;
    cnt_d   = cnt_q;
    if (sync_q == level_q) begin
      cnt_d = '0;
    end else if (cnt_q >= CW'(STABLE_CYC - 1)) begin
      level_d = sync_q;
      cnt_d   = '0;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q  <= RST_VAL;
      sync_q  <= RST_VAL;
      level_q <= RST_VAL;
      cnt_q   <= '0;
    end else begin
      meta_q  <= meta_d;
      sync_q  <= sync_d;
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end

  assign level_o = level_q;
endmodule // mdl_filter

// ### logic/mdl_pkg.sv
// Purpose: Shared constants for the modem DTE control-line block
// Assumes: 40 MHz clock, all pins active low
// Notes:   Option encodings are local to this block
package mdl_pkg;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned DTR_FILTER_MS    = 10;
  // Longest filter time, rounded down
  localparam int unsigned DTR_FILTER_CYC   = (CLK_HZ / 1000) * DTR_FILTER_MS;
  localparam int unsigned SYNC_STAGES      = 2;
  // Clear-to-send option encodings
  localparam logic [1:0]  CTS_FOLLOW_RTS   = 2'h0;
  localparam logic [1:0]  CTS_FORCED_ON    = 2'h1;
  localparam logic [1:0]  CTS_FOLLOW_CARR  = 2'h2;
  // Terminal-ready option encodings
  localparam logic [1:0]  DTR_IGNORE       = 2'h0;
  localparam logic [1:0]  DTR_TO_COMMAND   = 2'h1;
  localparam logic [1:0]  DTR_HANGUP       = 2'h2;
  localparam logic [1:0]  DTR_RESET        = 2'h3;
  // Values taken after reset
  localparam logic [1:0]  CTS_OPT_RST      = CTS_FOLLOW_RTS;
  localparam logic        DSR_TRACK_RST    = 1'b0;
  localparam logic        DCD_FORCE_RST    = 1'b0;
  localparam logic [1:0]  DTR_OPT_RST      = DTR_HANGUP;
  localparam logic        ASYNC_RST        = 1'b1;
  localparam logic [7:0]  RING_COUNT_RST   = 8'h00;
endpackage : mdl_pkg
